// File: jtp_tap.sv
// Test access port: controller, instruction and data registers, serial output
`timescale 1ns/10ps
module jtp_tap
    import jtp_pkg::*;
#(
    parameter int BSR_W = 16,
    parameter int DATA_W = 8,
    parameter int FIFO_DEPTH = 8,
    // Identification value is arbitrary
    parameter logic [31:0] ID_VALUE = 32'h0a5c_3001
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic test_port_enable_fuse,
    input wire logic pin_tck,
    input wire logic pin_tms,
    input wire logic pin_tdi,
    output logic pin_tdo_out,
    output logic pin_tdo_oe_n,
    output logic pull_up_en,
    output logic port_pins_gpio,
    input wire logic gpio_tdo_out,
    input wire logic gpio_tdo_oe_n,
    output logic test_logic_reset,
    output logic run_idle,
    output logic [3:0] instr,
    output logic extest_active,
    input wire logic [BSR_W-1:0] bsr_capture,
    output logic [BSR_W-1:0] bsr_update,
    output logic ext_sel,
    output logic debug_sel,
    output logic ext_capture,
    output logic ext_shift,
    output logic ext_update,
    output logic ext_tdi,
    input wire logic ext_tdo,
    output logic upd_valid,
    output logic [DATA_W-1:0] upd_data,
    input wire logic upd_ready
);

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic logic is_debug(input logic [3:0] code);
        return (code >= JTP_IR_DEBUG_FIRST) && (code <= JTP_IR_DEBUG_LAST);
    endfunction
    function automatic logic is_ext(input logic [3:0] code);
        return is_debug(code) || ((code >= JTP_IR_PROG_FIRST) && (code <= JTP_IR_PROG_LAST));
    endfunction
    function automatic logic is_bsr(input logic [3:0] code);
        return (code == JTP_IR_EXTEST) || (code == JTP_IR_SAMPLE);
    endfunction
    function automatic logic [JTP_LEN_W-1:0] dr_length(input logic [3:0] code);
        return (code == JTP_IR_IDCODE) ? JTP_LEN_IDCODE : is_bsr(code) ? JTP_LEN_W'(BSR_W) :
               (code == JTP_IR_USER_DATA) ? JTP_LEN_W'(DATA_W) : JTP_LEN_BYPASS;
    endfunction
    // New bit enters at the far end of the active length, bit 0 leaves first
    function automatic logic [JTP_DR_W-1:0] shift_lsb(input logic [JTP_DR_W-1:0] sh,
                                                      input logic [JTP_LEN_W-1:0] len,
                                                      input logic din);
        logic [JTP_DR_W-1:0] r;
        r = sh >> 1;
        for (int i = 0; i < JTP_DR_W; i++) begin
            r[i] = (i == int'(len) - 1) ? din : r[i];
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and TCK edge detection
    // ------------------------------------------------------------
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic fuse_s;
    logic tck_d;
    jtp_sync #(.WIDTH(4)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_async({test_port_enable_fuse, pin_tdi, pin_tms, pin_tck}),
        .out_sync({fuse_s, tdi_s, tms_s, tck_s})
    );
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end
    wire tck_rise = tck_s && !tck_d;
    wire tck_fall = !tck_s && tck_d;

    // ------------------------------------------------------------
    // Controller state machine
    // ------------------------------------------------------------
    jtp_state_t state;
    jtp_state_t next_state;
    always_comb begin
        case (state)
            JTP_TLR: next_state = tms_s ? JTP_TLR : JTP_RTI;
            JTP_RTI: next_state = tms_s ? JTP_SEL_DR : JTP_RTI;
            JTP_SEL_DR: next_state = tms_s ? JTP_SEL_IR : JTP_CAP_DR;
            JTP_CAP_DR: next_state = tms_s ? JTP_EX1_DR : JTP_SH_DR;
            JTP_SH_DR: next_state = tms_s ? JTP_EX1_DR : JTP_SH_DR;
            JTP_EX1_DR: next_state = tms_s ? JTP_UPD_DR : JTP_PAU_DR;
            JTP_PAU_DR: next_state = tms_s ? JTP_EX2_DR : JTP_PAU_DR;
            JTP_EX2_DR: next_state = tms_s ? JTP_UPD_DR : JTP_SH_DR;
            JTP_UPD_DR: next_state = tms_s ? JTP_SEL_DR : JTP_RTI;
            JTP_SEL_IR: next_state = tms_s ? JTP_TLR : JTP_CAP_IR;
            JTP_CAP_IR: next_state = tms_s ? JTP_EX1_IR : JTP_SH_IR;
            JTP_SH_IR: next_state = tms_s ? JTP_EX1_IR : JTP_SH_IR;
            JTP_EX1_IR: next_state = tms_s ? JTP_UPD_IR : JTP_PAU_IR;
            JTP_PAU_IR: next_state = tms_s ? JTP_EX2_IR : JTP_PAU_IR;
            JTP_EX2_IR: next_state = tms_s ? JTP_UPD_IR : JTP_SH_IR;
            JTP_UPD_IR: next_state = tms_s ? JTP_SEL_DR : JTP_RTI;
            default: next_state = JTP_TLR;
        endcase
    end
    // Fuse off holds the controller in reset; no test reset pin exists
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= JTP_TLR;
        end else if (!fuse_s) begin
            state <= JTP_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    wire in_cap_dr = tck_rise && (state == JTP_CAP_DR);
    wire in_sh_dr = tck_rise && (state == JTP_SH_DR);
    wire in_upd_dr = tck_rise && (state == JTP_UPD_DR);
    wire sh_state = (state == JTP_SH_DR) || (state == JTP_SH_IR);

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    logic [JTP_IR_W-1:0] ir_shift;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ir_shift <= JTP_IR_CAPTURE;
            instr <= JTP_IR_RESET;
        end else begin
            if (tck_rise && state == JTP_CAP_IR) begin
                ir_shift <= JTP_IR_CAPTURE;
            end else if (tck_rise && state == JTP_SH_IR) begin
                ir_shift <= {tdi_s, ir_shift[JTP_IR_W-1:1]};
            end
            if (state == JTP_TLR) begin
                instr <= JTP_IR_RESET;
            end else if (tck_rise && state == JTP_UPD_IR) begin
                instr <= ir_shift;
            end
        end
    end

    // ------------------------------------------------------------
    // Data register selection and capture
    // ------------------------------------------------------------
    logic [JTP_DR_W-1:0] dr_shift;
    logic lost;
    logic fifo_in_ready;
    wire sel_bsr = is_bsr(instr);
    wire sel_user = (instr == JTP_IR_USER_DATA);
    wire sel_ext = is_ext(instr);
    wire [JTP_LEN_W-1:0] dr_len = dr_length(instr);
    wire [JTP_DR_W-1:0] user_status = JTP_DR_W'({lost, !fifo_in_ready});
    wire [JTP_DR_W-1:0] dr_cap = (instr == JTP_IR_IDCODE) ? ID_VALUE :
                                 sel_bsr ? JTP_DR_W'(bsr_capture) :
                                 sel_user ? user_status : '0;
    wire user_push = in_upd_dr && sel_user && fifo_in_ready;
    wire user_drop = in_upd_dr && sel_user && !fifo_in_ready;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dr_shift <= '0;
        end else if (in_cap_dr) begin
            dr_shift <= dr_cap;
        end else if (in_sh_dr) begin
            dr_shift <= shift_lsb(dr_shift, dr_len, tdi_s);
        end
    end

    // A full FIFO refuses the update; the miss stays visible until next capture
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lost <= 1'b0;
        end else if (user_drop) begin
            lost <= 1'b1;
        end else if (in_cap_dr && sel_user) begin
            lost <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bsr_update <= '0;
        end else if (in_upd_dr && sel_bsr) begin
            bsr_update <= dr_shift[BSR_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // External programming and debug chains
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ext_capture <= 1'b0;
            ext_shift <= 1'b0;
            ext_update <= 1'b0;
            ext_tdi <= 1'b0;
            ext_sel <= 1'b0;
            debug_sel <= 1'b0;
        end else begin
            ext_capture <= in_cap_dr && sel_ext;
            ext_shift <= in_sh_dr && sel_ext;
            ext_update <= in_upd_dr && sel_ext;
            ext_tdi <= tdi_s;
            ext_sel <= sel_ext;
            debug_sel <= is_debug(instr);
        end
    end

    // ------------------------------------------------------------
    // Update FIFO toward user logic
    // ------------------------------------------------------------
    jtp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(user_push),
        .in_data(dr_shift[DATA_W-1:0]),
        .in_ready(fifo_in_ready),
        .out_valid(upd_valid),
        .out_data(upd_data),
        .out_ready(upd_ready)
    );

    // ------------------------------------------------------------
    // Serial output and pin mode
    // ------------------------------------------------------------
    wire tdo_bit = (state == JTP_SH_IR) ? ir_shift[0] : (sel_ext ? ext_tdo : dr_shift[0]);
    // Falling-edge launch gives the tester half a period of setup
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_tdo_out <= 1'b0;
            pin_tdo_oe_n <= 1'b1;
        end else if (!fuse_s) begin
            pin_tdo_out <= gpio_tdo_out;
            pin_tdo_oe_n <= gpio_tdo_oe_n;
        end else if (tck_fall) begin
            pin_tdo_out <= tdo_bit;
            pin_tdo_oe_n <= !sh_state;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pull_up_en <= 1'b0;
            port_pins_gpio <= 1'b1;
            test_logic_reset <= 1'b1;
            run_idle <= 1'b0;
            extest_active <= 1'b0;
        end else begin
            pull_up_en <= fuse_s;
            port_pins_gpio <= !fuse_s;
            test_logic_reset <= (state == JTP_TLR);
            run_idle <= (state == JTP_RTI);
            extest_active <= (instr == JTP_IR_EXTEST);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [JTP_TMS_CNT_W-1:0] tms_hi_cnt;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tms_hi_cnt <= '0;
        end else if (tck_rise) begin
            if (!tms_s) begin
                tms_hi_cnt <= '0;
            end else if (tms_hi_cnt != JTP_TLR_TMS_COUNT) begin
                tms_hi_cnt <= tms_hi_cnt + 1'b1;
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_step;
        tck_rise && fuse_s && state == JTP_RTI && tms_s |=> state == JTP_SEL_DR;
    endproperty
    a_step: assert property (p_step) else $error("idle with TMS high did not select DR");
    property p_five_high;
        tms_hi_cnt == JTP_TLR_TMS_COUNT |-> state == JTP_TLR;
    endproperty
    a_five_high: assert property (p_five_high) else $error("five TMS highs missed reset state");
    property p_fuse_off;
        !fuse_s |=> state == JTP_TLR && port_pins_gpio && !pull_up_en;
    endproperty
    a_fuse_off: assert property (p_fuse_off) else $error("fuse off did not hold reset");
    property p_ir_capture;
        tck_rise && fuse_s && state == JTP_CAP_IR |=> ir_shift == JTP_IR_CAPTURE;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("IR capture value wrong");
    property p_ir_hold;
        !$stable(instr) |-> ($past(state) == JTP_UPD_IR && $past(tck_rise)) || $past(state) == JTP_TLR;
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("instruction changed outside update");
    property p_id_capture;
        in_cap_dr && fuse_s && instr == JTP_IR_IDCODE |=> dr_shift == ID_VALUE;
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("ID capture wrong");
    property p_id_shift;
        in_sh_dr && fuse_s && instr == JTP_IR_IDCODE |=> dr_shift[31] == $past(tdi_s);
    endproperty
    a_id_shift: assert property (p_id_shift) else $error("TDI not entering at MSB end");
    property p_bsr_update;
        !$stable(bsr_update) |-> $past(state) == JTP_UPD_DR && $past(tck_rise);
    endproperty
    a_bsr_update: assert property (p_bsr_update) else $error("boundary output changed outside update");
    property p_nav_only;
        tck_rise && state inside {JTP_EX1_DR, JTP_PAU_DR, JTP_EX2_DR} |=>
            $stable(dr_shift) && !ext_shift && !ext_capture && !ext_update;
    endproperty
    a_nav_only: assert property (p_nav_only) else $error("activity in exit or pause");
    property p_tdo_launch;
        tck_fall && fuse_s && state == JTP_SH_IR |=> !pin_tdo_oe_n && pin_tdo_out == $past(ir_shift[0]);
    endproperty
    a_tdo_launch: assert property (p_tdo_launch) else $error("TDO not launched on falling edge");
    property p_tdo_steady;
        fuse_s && !tck_fall |=> $stable(pin_tdo_out) && $stable(pin_tdo_oe_n);
    endproperty
    a_tdo_steady: assert property (p_tdo_steady) else $error("TDO moved without falling edge");
    property p_private;
        instr inside {[JTP_IR_DEBUG_FIRST:JTP_IR_DEBUG_LAST]} |=> debug_sel && ext_sel;
    endproperty
    a_private: assert property (p_private) else $error("private code not routed to debug");
    c_shift_ir: cover property (tck_rise && state == JTP_SH_IR && tms_s);
    c_bsr_update: cover property (in_upd_dr && sel_bsr);
    c_fifo_push: cover property (user_push);
    c_fifo_drop: cover property (user_drop);
    c_reset_walk: cover property (tms_hi_cnt == JTP_TLR_TMS_COUNT);
endmodule

// File: jtp_pkg.sv
// Shared constants and types for the test access port block
package jtp_pkg;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        JTP_TLR    = 4'h0,
        JTP_RTI    = 4'h1,
        JTP_SEL_DR = 4'h2,
        JTP_CAP_DR = 4'h3,
        JTP_SH_DR  = 4'h4,
        JTP_EX1_DR = 4'h5,
        JTP_PAU_DR = 4'h6,
        JTP_EX2_DR = 4'h7,
        JTP_UPD_DR = 4'h8,
        JTP_SEL_IR = 4'h9,
        JTP_CAP_IR = 4'ha,
        JTP_SH_IR  = 4'hb,
        JTP_EX1_IR = 4'hc,
        JTP_PAU_IR = 4'hd,
        JTP_EX2_IR = 4'he,
        JTP_UPD_IR = 4'hf
    } jtp_state_t;

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    localparam int JTP_IR_W = 4;
    localparam logic [3:0] JTP_IR_CAPTURE = 4'h1;
    localparam logic [3:0] JTP_IR_EXTEST = 4'h0;
    localparam logic [3:0] JTP_IR_IDCODE = 4'h1;
    localparam logic [3:0] JTP_IR_SAMPLE = 4'h2;
    localparam logic [3:0] JTP_IR_USER_DATA = 4'h3;
    localparam logic [3:0] JTP_IR_PROG_FIRST = 4'h4;
    localparam logic [3:0] JTP_IR_PROG_LAST = 4'h7;
    localparam logic [3:0] JTP_IR_DEBUG_FIRST = 4'h8;
    localparam logic [3:0] JTP_IR_DEBUG_LAST = 4'hb;
    localparam logic [3:0] JTP_IR_BYPASS = 4'hf;
    localparam logic [3:0] JTP_IR_RESET = JTP_IR_IDCODE;

    // ------------------------------------------------------------
    // Data registers and counts
    // ------------------------------------------------------------
    localparam int JTP_DR_W = 32;
    localparam int JTP_LEN_W = 6;
    localparam logic [5:0] JTP_LEN_IDCODE = 6'h20;
    localparam logic [5:0] JTP_LEN_BYPASS = 6'h01;
    localparam int JTP_TMS_CNT_W = 3;
    localparam logic [2:0] JTP_TLR_TMS_COUNT = 3'h5;

endpackage

// File: jtp_sync.sv
// Two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/10ps
module jtp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_async,
    output logic [WIDTH-1:0] out_sync
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            out_sync <= '0;
        end else begin
            meta <= in_async;
            out_sync <= meta;
        end
    end

endmodule

// File: jtp_fifo.sv
// Small FIFO with registered output stage, valid and ready on both sides
`timescale 1ns/10ps
module jtp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;

    wire push = in_valid && in_ready;
    wire load_out = (count != '0) && (!out_valid || out_ready);
    assign in_ready = (count != FULL);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (load_out) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            count <= count + CW'(push) - CW'(load_out);
        end
    end

endmodule

// File: jtp_host.sv
// Model of the external test controller on the link pins
`timescale 1ns/10ps
module jtp_host (
    output logic pin_tck,
    output logic pin_tms,
    output logic pin_tdi,
    input wire logic pin_tdo_out,
    input wire logic pin_tdo_oe_n
);
    logic last = 1'b0;
    initial begin
        pin_tck = 1'b0;
        pin_tms = 1'b1;
        pin_tdi = 1'b1;
    end
    // ------------------------------------------------------------
    // Link steps
    // ------------------------------------------------------------
    // A released TDO reads as the inverse of its last level, so a stale bit never passes
    task automatic step(input logic m, input logic d, output logic b);
        #16 pin_tms = m;
        pin_tdi = d;
        #16 b = pin_tdo_oe_n ? ~last : pin_tdo_out;
        last = b;
        pin_tck = 1'b1;
        #32 pin_tck = 1'b0;
    endtask
    task automatic tlr();
        logic b;
        repeat (5) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
    // Stops in Exit1 so the caller can look before the update
    task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
        logic b;
        q = '0;
        step(1'b1, 1'b1, b);
        if (ir) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
    endtask
    task automatic upd();
        logic b;
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule

// File: tb.sv
// Self-checking bench for the test access port block
`timescale 1ns/10ps
module tb;
    import jtp_pkg::*;
    localparam logic [31:0] ID = 32'h5e1f_0b2d; // Arbitrary value
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic test_port_enable_fuse = 1'b1;
    logic upd_ready = 1'b0;
    logic gpio_tdo_out = 1'b0;
    logic gpio_tdo_oe_n = 1'b1;
    logic [7:0] ext_sr = 8'h00;
    wire ext_tdo = ext_sr[0];
    logic ext_capture, ext_shift, ext_update, ext_tdi;
    logic [15:0] bsr_capture = 16'h0000;
    logic pin_tck, pin_tms, pin_tdi, pin_tdo_out, pin_tdo_oe_n, pull_up_en, port_pins_gpio;
    logic test_logic_reset, run_idle, extest_active, ext_sel, debug_sel, upd_valid;
    logic [3:0] instr;
    logic [15:0] bsr_update;
    logic [7:0] upd_data;
    logic [31:0] q;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_ext_upd = 0;
    always #2.5 clk_sys = ~clk_sys;
    // Stand-in external chain: fixed word on capture, LSB first on shift
    always @(posedge clk_sys) begin
        if (ext_capture) ext_sr <= 8'h5a;
        else if (ext_shift) ext_sr <= {ext_tdi, ext_sr[7:1]};
        if (ext_update) n_ext_upd <= n_ext_upd + 1;
    end
    jtp_tap #(.ID_VALUE(ID)) u_jtp_tap (
        .clk_sys, .resetn, .test_port_enable_fuse, .pin_tck, .pin_tms, .pin_tdi, .pin_tdo_out,
        .pin_tdo_oe_n, .pull_up_en, .port_pins_gpio, .gpio_tdo_out, .gpio_tdo_oe_n, .test_logic_reset,
        .run_idle, .instr, .extest_active, .bsr_capture, .bsr_update, .ext_sel, .debug_sel, .ext_capture,
        .ext_shift, .ext_update, .ext_tdi, .ext_tdo, .upd_valid, .upd_data, .upd_ready);
    jtp_host u_jtp_host (.pin_tck, .pin_tms, .pin_tdi, .pin_tdo_out, .pin_tdo_oe_n);
    // ------------------------------------------------------------
    // Helpers and scenarios
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wv();
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            if (upd_valid === 1'b1) break;
        end
        if (i == 40) begin
            n_mismatch++;
            $display("[ERR] %0t no word offered by the update queue", $time);
            give_verdict();
        end
    endtask
    task automatic ir(input logic [3:0] c);
        u_jtp_host.scan(1'b1, 4, 32'(c), q);
        chk(32'(q[3:0]), 32'h1);
        u_jtp_host.upd();
    endtask
    task automatic t_reset();
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk({29'h0, test_logic_reset, pull_up_en, port_pins_gpio}, 32'h6);
        chk(32'(instr), 32'(JTP_IR_RESET));
        u_jtp_host.tlr();
        chk(32'(run_idle), 32'h1);
    endtask
    task automatic t_ir();
        u_jtp_host.scan(1'b1, 4, 32'h3, q);
        chk(32'(q[3:0]), 32'h1);
        repeat (6) @(posedge clk_sys);
        chk({27'h0, pin_tdo_oe_n, instr}, 32'h11);
        u_jtp_host.upd();
        chk(32'(instr), 32'h3);
    endtask
    task automatic t_fifo();
        for (int k = 0; k < 10; k++) begin
            u_jtp_host.scan(1'b0, 8, 32'h10 + k, q);
            if (k == 9) chk(32'(q[1:0]), 32'h1);
            u_jtp_host.upd();
        end
        u_jtp_host.scan(1'b0, 8, 32'h0, q);
        chk(32'(q[1:0]), 32'h3);
        u_jtp_host.upd();
        for (int k = 0; k < 9; k++) begin
            wv();
            chk(32'(upd_data), 32'h10 + k);
            @(posedge clk_sys);
            upd_ready <= 1'b1;
            @(posedge clk_sys);
            upd_ready <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
        chk(32'(upd_valid), 32'h0);
    endtask
    task automatic t_extest();
        @(posedge clk_sys);
        bsr_capture <= 16'hc35a;
        ir(4'h0);
        chk(32'(extest_active), 32'h1);
        u_jtp_host.scan(1'b0, 16, 32'h9e17, q);
        chk(32'(q[15:0]), 32'hc35a);
        chk(32'(bsr_update), 32'h0);
        u_jtp_host.upd();
        chk(32'(bsr_update), 32'h9e17);
    endtask
    task automatic t_ext();
        ir(4'h4);
        u_jtp_host.scan(1'b0, 8, 32'h3c, q);
        chk(32'(q[7:0]), 32'h5a);
        chk(32'(ext_sr), 32'h3c);
        chk(32'(n_ext_upd), 32'h0);
        u_jtp_host.upd();
        chk(32'(n_ext_upd), 32'h1);
    endtask
    task automatic t_sel();
        for (int c = 7; c < 13; c++) begin
            ir(4'(c));
            chk({30'h0, ext_sel, debug_sel}, {30'h0, 1'(c > 3 && c < 12), 1'(c > 7 && c < 12)});
        end
    endtask
    task automatic t_idcode();
        u_jtp_host.scan(1'b0, 3, 32'h0, q);
        chk(32'(q[0]), 32'h0);
        u_jtp_host.tlr();
        chk(32'(instr), 32'h1);
        u_jtp_host.scan(1'b0, 32, 32'h0, q);
        chk(q, ID);
        u_jtp_host.upd();
    endtask
    task automatic t_fuse();
        ir(4'h3);
        @(posedge clk_sys);
        test_port_enable_fuse <= 1'b0;
        gpio_tdo_out <= 1'b1;
        gpio_tdo_oe_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({23'h0, port_pins_gpio, pull_up_en, test_logic_reset, pin_tdo_out, pin_tdo_oe_n, instr}, 32'h161);
    endtask
    initial begin
        t_reset();
        t_ir();
        t_fifo();
        t_extest();
        t_ext();
        t_sel();
        t_idcode();
        t_fuse();
        give_verdict();
    end
    initial begin
        #100us;
        n_mismatch++;
        $display("[ERR] %0t run did not finish in time", $time);
        give_verdict();
    end
endmodule
